/* File: verilog/adc_conversion_sequencer.sv */
// Conversion sequencer with indirect module register port
`timescale 1ns/1ns
`default_nettype none
`include "adc_seq_defs.svh"
module adc_conversion_sequencer #(
    parameter int MAX_WAIT = 2048 * 512 * 25
) (
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic [15:0]           module_address_port,
    input  wire logic [15:0]           module_data_port,
    input  wire logic [15:0]           module_control_port,
    input  wire logic [15:0]           analog_result,
    input  wire logic                  analog_done,
    output logic                       control_initiate_clear,
    output logic [15:0]                read_data,
    output logic                       read_valid,
    output logic                       cpu_stall,
    output logic                       analog_start,
    output adc_seq_pkg::conv_cfg_s     analog_cfg
);
    // ========================================
    // Registers and state
    logic [15:0] start_q;
    logic [15:0] res_q [3];
    logic [15:0] set_a_q [3];
    logic [15:0] set_b_q [3];
    adc_seq_pkg::seq_state_e state_q;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic        done_sync1_q;
    logic        done_sync2_q;
    logic        initiate_q;
    logic        is_read;
    logic        go;
    logic [7:0]  addr;
    logic        ch_one;
    logic        ch_two;
    logic        tmp;
    logic        any_start;
    logic [1:0]  tgt;
    logic [3:0]  src;
    logic [15:0] cfg_a;
    logic [15:0] cfg_b;
    logic [15:0] rd_mux;
    logic [15:0] wr_mask;
    logic [11:0] res_cycles;
    logic [3:0]  div_shift;
    // ========================================
    // Command decode of the module control port
    assign go        = module_control_port[`BIT_INITIATE] && !initiate_q;
    assign is_read   = module_control_port[`BIT_READ];
    assign addr      = module_address_port[7:0];
    // Source priority
    assign ch_one    = start_q[`BIT_START_ONE];
    assign ch_two    = !ch_one && start_q[`BIT_START_TWO];
    assign src       = start_q[11:8];
    assign tmp       = !ch_one && !ch_two && start_q[`BIT_START_TEMP]
                       && (src == `SRC_DIFF);
    assign any_start = ch_one || ch_two || tmp;
    assign tgt       = ch_one ? 2'd0 : (ch_two ? 2'd1 : 2'd2);
    assign cfg_a     = set_a_q[tgt];
    assign cfg_b     = set_b_q[tgt];
    // Conversion length in converter clocks from resolution code
    always_comb begin
        case (cfg_a[6:4])
            3'd0:    res_cycles = 12'd256;
            3'd1:    res_cycles = 12'd320;
            3'd2:    res_cycles = 12'd512;
            3'd3:    res_cycles = 12'd640;
            3'd4:    res_cycles = 12'd800;
            3'd5:    res_cycles = 12'd1280;
            default: res_cycles = 12'd2048;
        endcase
    end
    // Total system cycles: converter clocks times divider times base period
    // Shift is widened first so divider codes 6 and 7 do not wrap
    assign div_shift = {1'b0, cfg_a[10:8]} + 4'd2;
    assign cnt_d     = 32'((32'(res_cycles) << div_shift) * `CYC_PER_ADC_CLK);
    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        case (addr)
            `OFS_START:      rd_mux = start_q;
            `OFS_RES_ONE:    rd_mux = res_q[0];
            `OFS_SET_ONE_A:  rd_mux = set_a_q[0];
            `OFS_SET_ONE_B:  rd_mux = set_b_q[0];
            `OFS_RES_TWO:    rd_mux = res_q[1];
            `OFS_SET_TWO_A:  rd_mux = set_a_q[1];
            `OFS_SET_TWO_B:  rd_mux = set_b_q[1];
            `OFS_RES_TEMP:   rd_mux = res_q[2];
            `OFS_SET_TEMP_A: rd_mux = set_a_q[2];
            `OFS_SET_TEMP_B: rd_mux = set_b_q[2];
            default:         rd_mux = `RST_ZERO;
        endcase
    end
    assign wr_mask = (addr == `OFS_SET_TEMP_B) ? `TEMP_B_MASK : `SET_B_MASK;
    // ========================================
    // Completion input synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            done_sync1_q <= 1'b0;
            done_sync2_q <= 1'b0;
        end else begin
            done_sync1_q <= analog_done;
            done_sync2_q <= done_sync1_q;
        end
    end
    // ========================================
    // Register port: one transfer per initiate, then self-clear pulse
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            initiate_q             <= 1'b0;
            control_initiate_clear <= 1'b0;
            read_data              <= `RST_ZERO;
            read_valid             <= 1'b0;
        end else begin
            initiate_q             <= module_control_port[`BIT_INITIATE];
            control_initiate_clear <= go;
            read_valid             <= go && is_read;
            if (go && is_read) begin
                read_data <= rd_mux;
            end
        end
    end
    // Configuration registers, writes blocked while converting
    for (genvar i = 0; i < 3; i++) begin : g_set
        always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
                set_a_q[i] <= `RST_ZERO;
                set_b_q[i] <= `RST_SET_B;
                res_q[i]   <= `RST_ZERO;
            end else begin
                if (go && !is_read && state_q == adc_seq_pkg::ST_IDLE
                    && addr == 8'(`OFS_SET_ONE_A + 3 * i)) begin
                    set_a_q[i] <= module_data_port & 16'hFF7F;
                end
                if (go && !is_read && state_q == adc_seq_pkg::ST_IDLE
                    && addr == 8'(`OFS_SET_ONE_B + 3 * i)) begin
                    set_b_q[i] <= module_data_port & wr_mask;
                end
                if (state_q == adc_seq_pkg::ST_STORE && tgt == 2'(i)) begin
                    res_q[i] <= analog_result;
                end
            end
        end
    end
    // ========================================
    // Start register and conversion sequencer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            start_q      <= `RST_ZERO;
            state_q      <= adc_seq_pkg::ST_IDLE;
            cnt_q        <= 32'd0;
            cpu_stall    <= 1'b0;
            analog_start <= 1'b0;
            analog_cfg   <= '0;
        end else begin
            analog_start <= 1'b0;
            case (state_q)
                adc_seq_pkg::ST_IDLE: begin
                    if (go && !is_read && addr == `OFS_START) begin
                        start_q <= module_data_port & `START_MASK;
                    end else if (any_start) begin
                        state_q      <= adc_seq_pkg::ST_WAIT;
                        cnt_q        <= (cnt_d > 32'(MAX_WAIT)) ? 32'(MAX_WAIT) : cnt_d;
                        cpu_stall    <= 1'b1;
                        analog_start <= 1'b1;
                        analog_cfg.gain        <= cfg_a[15:11];
                        analog_cfg.clk_div     <= cfg_a[10:8];
                        analog_cfg.resolution  <= cfg_a[6:4];
                        analog_cfg.offset_sign <= cfg_a[3];
                        analog_cfg.offset_mag  <= cfg_a[2:0];
                        analog_cfg.bias        <= cfg_b[6:4];
                        analog_cfg.reference   <= cfg_b[1:0];
                        analog_cfg.source      <= src;
                        analog_cfg.forced_gain <= (src >= `SRC_SUPPLY)
                                                  && (src <= `SRC_BUF_LARGE);
                        analog_cfg.target      <= tgt;
                    end else if (start_q[`BIT_START_TEMP]) begin
                        start_q[`BIT_START_TEMP] <= 1'b0;
                    end
                end
                adc_seq_pkg::ST_WAIT: begin
                    if (done_sync2_q || cnt_q <= 32'd1) begin
                        state_q <= adc_seq_pkg::ST_STORE;
                    end else begin
                        cnt_q <= cnt_q - 32'd1;
                    end
                end
                adc_seq_pkg::ST_STORE: begin
                    state_q   <= adc_seq_pkg::ST_IDLE;
                    cpu_stall <= 1'b0;
                    // One write, one conversion: every start bit drops with the result
                    start_q[`BIT_START_ONE]  <= 1'b0;
                    start_q[`BIT_START_TWO]  <= 1'b0;
                    start_q[`BIT_START_TEMP] <= 1'b0;
                end
                default: state_q <= adc_seq_pkg::ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: verilog/adc_seq_defs.svh */
// Register offsets, field positions, reset values and timing counts of the sequencer
// Overview of operation
// - Start bit 2 converts channel one with its setup registers into its result.
// - Start bit 1 converts channel two with its setup registers into its result.
// - Start bit 0 converts the temperature sensor into the temperature result.
// - Processor is stalled for the whole conversion until the result is written.
// - All set start bits clear together when the one conversion finishes.
// - Channel one wins whatever other bits hold; select zero means differential pair.
// - Channel two wins over temperature when channel one is clear.
// - Temperature converts only alone with select zero; alone with nonzero select its bit just clears.
// - Nonzero select with channel start converts that single-ended source.
// - Source select sits in control bits 11..8; other upper bits unused.
// - Codes 1..3 pick bandgap, small amp and large amp outputs.
// - Codes 4..7 pick supply, ground and buffered converter outputs.
// - Codes 8 and 9 pick positive or negative input pin single-ended.
// - Supply, ground and buffered codes force the fixed reduced gain.
// - Setup A holds gain 15..11, clock 10..8, resolution 6..4.
// - Setup A holds offset sign bit 3 and magnitude 2..0.
// - Setup B holds bias code in bits 6..4.
// - Setup B of channels one and two holds reference select in bits 1..0.
// - Setup B registers reset to 0070h, all others to 0000h.
// - Processor loads address and data, then sets initiate bit 15, bit 14 read.
// - Initiate bit clears itself once the transfer is done.
// - Channel two and temperature setups share channel one field positions.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFS_START      8'h00
`define OFS_RES_ONE    8'h01
`define OFS_SET_ONE_A  8'h02
`define OFS_SET_ONE_B  8'h03
`define OFS_RES_TWO    8'h04
`define OFS_SET_TWO_A  8'h05
`define OFS_SET_TWO_B  8'h06
`define OFS_RES_TEMP   8'h07
`define OFS_SET_TEMP_A 8'h08
`define OFS_SET_TEMP_B 8'h09
`define RST_SET_B      16'h0070
`define RST_ZERO       16'h0000
`define BIT_START_ONE  2
`define BIT_START_TWO  1
`define BIT_START_TEMP 0
`define BIT_INITIATE   15
`define BIT_READ       14
`define START_MASK     16'h0F07
`define SET_B_MASK     16'h0073
`define TEMP_B_MASK    16'h0070
`define SRC_DIFF       4'h0
`define SRC_SUPPLY     4'h4
`define SRC_BUF_LARGE  4'h7
`define ADC_CLK_NS     250
`define SYS_CLK_NS     10
`define CYC_PER_ADC_CLK (`ADC_CLK_NS / `SYS_CLK_NS)
`endif

/* File: verilog/adc_seq_pkg.sv */
// Types shared by the conversion sequencer
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SRC_CH_ONE,
        SRC_CH_TWO,
        SRC_TEMP
    } target_e;
    typedef struct packed {
        logic [4:0] gain;
        logic [2:0] clk_div;
        logic [2:0] resolution;
        logic       offset_sign;
        logic [2:0] offset_mag;
        logic [2:0] bias;
        logic [1:0] reference;
        logic [3:0] source;
        logic       forced_gain;
        logic [1:0] target;
    } conv_cfg_s;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_STORE
    } seq_state_e;
endpackage

/* File: verif/adc_seq_monitor.sv */
// Port-level checker of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module adc_seq_monitor #(
    parameter int MAX_WAIT = 100
) (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic [15:0]            module_address_port,
    input wire logic [15:0]            module_data_port,
    input wire logic [15:0]            module_control_port,
    input wire logic [15:0]            analog_result,
    input wire logic                   analog_done,
    input wire logic                   control_initiate_clear,
    input wire logic [15:0]            read_data,
    input wire logic                   read_valid,
    input wire logic                   cpu_stall,
    input wire logic                   analog_start,
    input wire adc_seq_pkg::conv_cfg_s analog_cfg
);
    int stall_cnt_q;
    // ==========
    // Stall length counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stall_cnt_q <= 0;
        end else begin
            stall_cnt_q <= cpu_stall ? stall_cnt_q + 1 : 0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Request taken on the rise of the initiate bit
    sequence s_take;
        $rose(module_control_port[15]);
    endsequence
    sequence s_pulse;
        control_initiate_clear ##1 !control_initiate_clear;
    endsequence
    a_initiate_clear_pulse: assert property (s_take |=> s_pulse)
        else $error("initiate clear pulse missing");
    a_read_answer: assert property (s_take ##0 module_control_port[14] |=> read_valid)
        else $error("read answer missing");
    a_write_silent: assert property (s_take ##0 !module_control_port[14]
        |=> !read_valid)
        else $error("write gave read answer");
    a_start_stalls: assert property (analog_start |-> cpu_stall)
        else $error("start without stall");
    a_stall_starts: assert property ($rose(cpu_stall) |-> analog_start)
        else $error("stall without start");
    a_cfg_held: assert property (cpu_stall && !analog_start |-> $stable(analog_cfg))
        else $error("settings changed in conversion");
    a_temp_alone: assert property (analog_start && analog_cfg.target == 2'h2
        |-> analog_cfg.source == 4'h0)
        else $error("temperature with nonzero select");
    a_gain_forced: assert property (analog_start
        |-> analog_cfg.forced_gain == (analog_cfg.source inside {[4'h4:4'h7]}))
        else $error("forced gain wrong");
    a_done_ends_stall: assert property ($rose(analog_done) && cpu_stall
        |-> ##[1:6] !cpu_stall)
        else $error("stall outlasts done");
    a_stall_bounded: assert property (stall_cnt_q <= MAX_WAIT + 8)
        else $error("stall too long");
endmodule
bind adc_conversion_sequencer adc_seq_monitor #(.MAX_WAIT(MAX_WAIT)) i_adc_seq_monitor (
    .clk(clk), .rstn(rstn), .module_address_port(module_address_port),
    .module_data_port(module_data_port), .module_control_port(module_control_port),
    .analog_result(analog_result), .analog_done(analog_done), .read_data(read_data),
    .control_initiate_clear(control_initiate_clear), .read_valid(read_valid),
    .cpu_stall(cpu_stall), .analog_start(analog_start), .analog_cfg(analog_cfg));
`default_nettype wire

/* File: verif/adc_analog_model.sv */
// Behavioural converter answering each start after a fixed delay
`timescale 1ns/1ns
`default_nettype none
module adc_analog_model #(
    parameter int DELAY = 20
) (
    input wire logic                   clk,
    input wire logic                   rstn,
    input wire logic                   analog_start,
    input wire adc_seq_pkg::conv_cfg_s analog_cfg,
    output logic [15:0]                analog_result,
    output logic                       analog_done
);
    int          cnt_q;
    logic [15:0] value_q;
    // ==========
    // Delay counter and result latched from the settings at start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= 0;
            value_q <= 16'h0000;
        end else if (analog_start) begin
            cnt_q <= DELAY + 6;
            value_q <= {4'hC, 2'h0, analog_cfg.target, 4'h0, analog_cfg.source};
        end else if (cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    // Done held six cycles; released bus shows inverted value
    assign analog_done = cnt_q inside {[1:6]};
    assign analog_result = analog_done ? value_q : ~value_q;
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic                   clk;
    logic                   rstn;
    logic [15:0]            addr_q;
    logic [15:0]            wdata_q;
    logic [15:0]            ctrl_q;
    logic [15:0]            result;
    logic                   done;
    logic                   clr;
    logic [15:0]            rdata;
    logic                   rvalid;
    logic                   stall;
    logic                   start;
    adc_seq_pkg::conv_cfg_s cfg;
    logic [15:0]            got;
    int                     n_errors = 0;
    int                     n_compared = 0;
    int                     cycles = 0;
    adc_conversion_sequencer #(.MAX_WAIT(400)) i_adc_conversion_sequencer (
        .clk(clk), .rstn(rstn), .module_address_port(addr_q), .module_data_port(wdata_q),
        .module_control_port(ctrl_q), .analog_result(result), .analog_done(done),
        .control_initiate_clear(clr), .read_data(rdata), .read_valid(rvalid),
        .cpu_stall(stall), .analog_start(start), .analog_cfg(cfg));
    adc_analog_model i_adc_analog_model (.clk(clk), .rstn(rstn), .analog_start(start),
        .analog_cfg(cfg), .analog_result(result), .analog_done(done));
    // ==========
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors = n_errors + 1;
            conclude();
        end
    end
    task automatic check(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Module port transfer: hold initiate until the clear pulse
    task automatic access(input logic rd, input logic [7:0] a, input logic [15:0] d);
        int i;
        @(posedge clk);
        addr_q <= {8'h00, a};
        wdata_q <= d;
        ctrl_q <= {1'b1, rd, 14'h0000};
        i = 0;
        do begin
            @(posedge clk);
            #1;
            i++;
        end while (clr !== 1'b1 && i < 20);
        if (i >= 20) check(16'hDEAD, 16'h0000);
        got = rdata;
        @(posedge clk);
        ctrl_q <= 16'h0000;
        @(posedge clk);
    endtask
    task automatic wr_rd(input logic [7:0] a, input logic [15:0] d, input logic [15:0] e);
        access(1'b0, a, d);
        access(1'b1, a, 16'h0000);
        check(got, e);
    endtask
    task automatic reg_defaults;
        for (int a = 0; a < 11; a++) begin
            access(1'b1, a[7:0], 16'h0000);
            check(got, (a % 3 == 0 && a > 0 && a < 10) ? 16'h0070 : 16'h0000);
        end
    endtask
    // Start one conversion and judge settings, stall, result and start bits
    task automatic convert(input logic [15:0] c, input logic [1:0] t, input logic [15:0] a,
                           input logic [15:0] b, input logic run);
        int          i;
        logic        f;
        logic [15:0] w;
        f = c[11:8] inside {[4'h4:4'h7]};
        access(1'b0, 8'h00, c);
        #1;
        check({15'h0000, stall}, {15'h0000, run});
        if (run) begin
            check({14'h0000, cfg.target}, {14'h0000, t});
            check({12'h000, cfg.source}, {12'h000, c[11:8]});
            check({15'h0000, cfg.forced_gain}, {15'h0000, f});
            if (!f) check({11'h000, cfg.gain}, {11'h000, a[15:11]});
            w = {5'h00, cfg.clk_div, 1'h0, cfg.resolution, cfg.offset_sign, cfg.offset_mag};
            check(w, a & 16'h07FF);
            check({9'h000, cfg.bias, 2'h0, cfg.reference}, b);
        end
        // Wait for the stall to end, sampled after the edge has settled
        i = 0;
        while (i < 600 && stall !== 1'b0) begin
            @(posedge clk);
            #1;
            i++;
        end
        check({15'h0000, stall}, 16'h0000);
        if (run) begin
            access(1'b1, (t == 2'h0) ? 8'h01 : (t == 2'h1) ? 8'h04 : 8'h07, 16'h0000);
            check(got, {4'hC, 2'h0, t, 4'h0, c[11:8]});
        end
        access(1'b1, 8'h00, 16'h0000);
        check(got, {4'h0, c[11:8], 8'h00});
    endtask
    // ==========
    // Main sequence
    initial begin
        rstn = 1'b0;
        addr_q = 16'h0000;
        wdata_q = 16'h0000;
        ctrl_q = 16'h0000;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        reg_defaults();
        // Channel one keeps reference code 3 for the supply measurement below
        wr_rd(8'h03, 16'hFFFF, 16'h0073);
        wr_rd(8'h09, 16'hFFFF, 16'h0070);
        wr_rd(8'h01, 16'h1234, 16'h0000);
        // Unused bit 7 of setup A reads back zero
        wr_rd(8'h02, 16'hA5B3, 16'hA533);
        wr_rd(8'h05, 16'h4A21, 16'h4A21);
        wr_rd(8'h08, 16'h1800, 16'h1800);
        convert(16'h0007, 2'h0, 16'hA533, 16'h0073, 1'b1);
        convert(16'h0003, 2'h1, 16'h4A21, 16'h0070, 1'b1);
        convert(16'h0001, 2'h2, 16'h1800, 16'h0070, 1'b1);
        convert(16'h0301, 2'h2, 16'h1800, 16'h0070, 1'b0);
        for (int s = 1; s < 10; s++) begin
            convert({4'h0, s[3:0], 8'h04}, 2'h0, 16'hA533, 16'h0073, 1'b1);
        end
        convert(16'h0602, 2'h1, 16'h4A21, 16'h0070, 1'b1);
        convert(16'h0902, 2'h1, 16'h4A21, 16'h0070, 1'b1);
        conclude();
    end
    task automatic conclude;
        $display("Counts: %0d mismatches, %0d compared", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
endmodule
`default_nettype wire
